/* File: design/sideband_map.vh */
// Constants for the reset-request and multicast-event sideband pin logic.
// Assumes inclusion by the design files under design/.
`ifndef SIDEBAND_MAP_VH
`define SIDEBAND_MAP_VH

// Register-bus clock period and the edge-to-edge stability figure on the event pin
`define SB_CLK_PERIOD_NS   10
`define SB_STABLE_CYCLES   10
// Reset values
`define SB_RST_IND_OFF     1'b0
`define SB_EVT_LEVEL_RST   1'b0
// Soft-reset indication states
`define SB_ST_IDLE         1'b0
`define SB_ST_HOLD         1'b1

`endif

/* File: design/edge_sync.v */
// Two-stage synchroniser with a single-pulse edge detector on the synchronised level.
// Assumes the input is asynchronous to i_clk_sys and stable per the pin timing.
`timescale 1ns/1ps
`include "sideband_map.vh"

module edge_sync (
  input  wire i_clk_sys,
  input  wire i_reset_n,
  input  wire i_async,
  output wire o_level,
  output wire o_edge
);

  reg meta_r;
  reg sync_r;
  reg prev_r;

  // The first stage feeds only the second stage
  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= i_async; // R12
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign o_level = sync_r;
  assign o_edge  = sync_r ^ prev_r; // R12

endmodule // edge_sync

/* File: design/sideband_pins.v */
// Soft-reset indication and multicast-event pin logic of a serial packet switch.
// Assumes the port logic supplies same-clock pulses for reset requests and received
// event symbols, and a done pulse from the self-reset sequencer.
`timescale 1ns/1ps
`include "sideband_map.vh"

// Requirements behind this block
// R1 - Valid link reset request asserts soft-reset indication
// R2 - Without self-reset, hold until software clears
// R3 - With self-reset, hold until sequence completes
// R4 - Hard reset deasserts indication, stays deasserted
// R5 - No port-write; indication is the only notice
// R6 - Hard reset asynchronous, active low, whole block
// R7 - Event pin edge sends symbol on enabled ports
// R8 - Received symbol on enabled port toggles pin
// R9 - Far side holds event input ten cycles
// R10 - Serial reference clock feeds serializer and logic
// R11 - Register-bus clock times pin stability windows
// R12 - Synchronise event input, one trigger per edge
module sideband_pins #(
  parameter NUM_PORTS = 8
) (
  input  wire                 i_clk_sys,
  input  wire                 i_reset_n,
  input  wire [NUM_PORTS-1:0] i_port_reset_req,
  input  wire                 i_self_reset_sel,
  input  wire                 i_sw_clear_req,
  input  wire                 i_self_reset_done,
  output reg                  o_soft_reset_indication_n_o,
  output reg                  o_soft_reset_indication_n_oe,
  output reg                  o_self_reset_start,
  output reg                  o_reset_req_recorded,
  input  wire                 i_multicast_event_pin_i,
  input  wire                 i_multicast_event_pin_dir_out,
  output reg                  o_multicast_event_pin_o,
  output reg                  o_multicast_event_pin_oe,
  input  wire [NUM_PORTS-1:0] i_port_mc_enable,
  input  wire [NUM_PORTS-1:0] i_port_mc_received,
  output reg  [NUM_PORTS-1:0] o_port_mc_send,
  output reg                  o_pin_timing_violation
);

  // ==========================================================================
  // Soft-reset indication
  // ==========================================================================
  // R10: i_clk_sys is the logic clock derived from the serial reference by the
  // clock generator outside this block; R11: pin windows are counted on it.
  reg  state_r;
  reg  state_nxt;
  wire any_req = |i_port_reset_req;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      `SB_ST_IDLE: begin
        if (any_req)
          state_nxt = `SB_ST_HOLD; // R1
      end
      `SB_ST_HOLD: begin
        // A fresh request in the clearing cycle keeps the indication up
        if (any_req)
          state_nxt = `SB_ST_HOLD;
        else if (!i_self_reset_sel && i_sw_clear_req)
          state_nxt = `SB_ST_IDLE; // R2
        else if (i_self_reset_sel && i_self_reset_done)
          state_nxt = `SB_ST_IDLE; // R3
      end
      default: state_nxt = `SB_ST_IDLE;
    endcase
  end

  // R5: no port-write path exists; the open-drain pin is the only notice
  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r                      <= `SB_ST_IDLE; // R4 R6
      o_soft_reset_indication_n_o  <= 1'b0;
      o_soft_reset_indication_n_oe <= `SB_RST_IND_OFF; // R4
      o_self_reset_start           <= 1'b0;
      o_reset_req_recorded         <= 1'b0;
    end else begin
      state_r                      <= state_nxt;
      o_soft_reset_indication_n_o  <= 1'b0;
      o_soft_reset_indication_n_oe <= (state_nxt == `SB_ST_HOLD); // R1 R5
      o_reset_req_recorded         <= (state_nxt == `SB_ST_HOLD);
      o_self_reset_start           <= (state_r == `SB_ST_IDLE) && any_req && i_self_reset_sel; // R3
    end
  end

  // ==========================================================================
  // Multicast-event pin
  // ==========================================================================
  wire evt_level;
  wire evt_edge;

  edge_sync u_edge_sync (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .i_async   (i_multicast_event_pin_i),
    .o_level   (evt_level),
    .o_edge    (evt_edge)
  );

  reg       dir_meta_r;
  reg       dir_r;
  reg [3:0] stable_cnt_r;
  wire      rx_any = |(i_port_mc_received & i_port_mc_enable);

  // Stability counter only flags a violation of the far side's hold time;
  // the edge is still honoured so no event is dropped.
  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dir_meta_r               <= 1'b0;
      dir_r                    <= 1'b0;
      stable_cnt_r             <= 4'h0;
      o_multicast_event_pin_o  <= `SB_EVT_LEVEL_RST;
      o_multicast_event_pin_oe <= 1'b0;
      o_port_mc_send           <= {NUM_PORTS{1'b0}};
      o_pin_timing_violation   <= 1'b0;
    end else begin
      dir_meta_r               <= i_multicast_event_pin_dir_out;
      dir_r                    <= dir_meta_r;
      o_multicast_event_pin_oe <= dir_r;
      o_port_mc_send           <= (evt_edge && !dir_r) ? i_port_mc_enable : {NUM_PORTS{1'b0}}; // R7
      if (dir_r && rx_any)
        o_multicast_event_pin_o <= ~o_multicast_event_pin_o; // R8
      if (evt_edge)
        stable_cnt_r <= 4'h0;
      else if (stable_cnt_r != 4'hF)
        stable_cnt_r <= stable_cnt_r + 4'h1;
      o_pin_timing_violation <= !dir_r && evt_edge && (stable_cnt_r < (`SB_STABLE_CYCLES - 1)); // R9 R11
    end
  end

endmodule // sideband_pins

/* File: sim/sideband_pins_properties.sv */
// Port checker for sideband_pins.
// Assumes NUM_PORTS is 8.
`timescale 1ns/1ps
module sideband_pins_properties (
  input wire i_clk_sys, i_reset_n, i_self_reset_sel, i_sw_clear_req, i_self_reset_done,
  input wire o_soft_reset_indication_n_o, o_soft_reset_indication_n_oe, o_self_reset_start,
  input wire o_reset_req_recorded, o_multicast_event_pin_o, o_multicast_event_pin_oe,
  input wire [7:0] i_port_reset_req, i_port_mc_enable, i_port_mc_received, o_port_mc_send
);
  wire ind = o_soft_reset_indication_n_oe;
  wire sel = i_self_reset_sel;
  wire req = |i_port_reset_req;
  wire mo  = o_multicast_event_pin_o;
  wire moe = o_multicast_event_pin_oe;
  wire rx  = |(i_port_mc_received & i_port_mc_enable);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  AST_SET: assert property (req |=> ind) else $error("no set");
  AST_HOLD: assert property (ind && !(sel ? i_self_reset_done : i_sw_clear_req) |=> ind) else $error("drop");
  AST_CLEAR: assert property (ind && !sel && i_sw_clear_req && !req |=> !ind) else $error("no clear");
  AST_DONE: assert property (ind && sel && i_self_reset_done && !req |=> !ind) else $error("no release");
  AST_START: assert property (req && !ind && sel |=> o_self_reset_start) else $error("no start");
  AST_OD: assert property (!o_soft_reset_indication_n_o && o_reset_req_recorded == ind) else $error("pin");
  AST_HARD: assert property ($rose(i_reset_n) |-> !ind) else $error("on after reset");
  AST_TOGGLE: assert property (moe && rx ##1 moe |-> mo != $past(mo)) else $error("no toggle");
  AST_SEND: assert property (o_port_mc_send != 8'h00 |=> o_port_mc_send == 8'h00) else $error("stuck");
  cover property (ind && sel && i_self_reset_done);
  cover property (o_port_mc_send != 8'h00);
  cover property (moe && rx);
endmodule // sideband_pins_properties
bind sideband_pins sideband_pins_properties u_chk (.*);

/* File: sim/pin_host_model.sv */
// Board side: pull-up on the reset line and the host on the event pin.
// Assumes the design's pin outputs arrive here.
`timescale 1ns/1ps
module pin_host_model (
  input  wire i_clk_sys,
  input  wire i_sr_oe,
  input  wire i_mc_o,
  input  wire i_mc_oe,
  output wire o_sr_line,
  output wire o_mc_line
);
  reg lvl = 1'b0;
  assign o_sr_line = ~i_sr_oe;
  assign o_mc_line = i_mc_oe ? i_mc_o : lvl;
  // Quiet span on both sides of every edge
  task flip; begin
    repeat (10) @(negedge i_clk_sys);
    lvl = ~lvl;
    repeat (10) @(negedge i_clk_sys);
  end endtask
endmodule // pin_host_model

/* File: sim/sideband_pins_tb.sv */
// Bench for sideband_pins with the board-side model.
// Assumes the design files compile first.
`timescale 1ns/1ps
module sideband_pins_tb;
  reg clk = 1'b0, rst_n = 1'b0, sel = 1'b0, clr = 1'b0, done = 1'b0, dir = 1'b0, v = 1'b0;
  reg [7:0] req = 8'h00, en = 8'h00, rx = 8'h00, got, cnt, e;
  wire sr_o, sr_oe, start, rec, mc_o, mc_oe, viol, sr_line, mc_line;
  wire [7:0] send;
  integer n_mismatch = 0, checked = 0, i;
  always #5 clk = ~clk;
  sideband_pins u_dut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_port_reset_req(req), .i_self_reset_sel(sel),
    .i_sw_clear_req(clr), .i_self_reset_done(done), .o_soft_reset_indication_n_o(sr_o),
    .o_soft_reset_indication_n_oe(sr_oe), .o_self_reset_start(start), .o_reset_req_recorded(rec),
    .i_multicast_event_pin_i(mc_line), .i_multicast_event_pin_dir_out(dir), .o_multicast_event_pin_o(mc_o),
    .o_multicast_event_pin_oe(mc_oe), .i_port_mc_enable(en), .i_port_mc_received(rx), .o_port_mc_send(send),
    .o_pin_timing_violation(viol));
  pin_host_model u_host (.i_clk_sys(clk), .i_sr_oe(sr_oe), .i_mc_o(mc_o), .i_mc_oe(mc_oe),
    .o_sr_line(sr_line), .o_mc_line(mc_line));
  task cyc(input integer n); repeat (n) @(negedge clk); endtask
  task chk(input [7:0] seen, input [7:0] exp); begin
    checked = checked + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  end endtask
  task give_verdict; begin
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  end endtask
  // The wrong terminator for the policy comes first and must be ignored
  task t_soft(input s); begin
    sel = s; req = 8'h08; cyc(1); req = 8'h00;
    chk(sr_line, 1'b0);
    chk(start, s);
    {clr, done} = s ? 2'b10 : 2'b01; cyc(1); {clr, done} = 2'b00; cyc(2);
    chk(sr_line, 1'b0);
    {clr, done} = s ? 2'b01 : 2'b10; cyc(1); {clr, done} = 2'b00;
    chk(sr_line, 1'b1);
    chk(rec, 1'b0);
  end endtask
  task t_evt; begin
    dir = 1'b0; en = 8'hA5; cyc(4);
    for (i = 0; i < 2; i = i + 1) begin
      got = 8'h00; cnt = 8'h00; v = 1'b0;
      fork
        u_host.flip();
        repeat (20) begin @(negedge clk); v = v | viol; if (send != 8'h00) begin got = send; cnt = cnt + 8'h01; end end
      join
      chk(got, 8'hA5);
      chk(cnt, 8'h01);
      chk(v, 1'b0);
    end
    // Two edges only three cycles apart break the hold time and must be flagged
    v = 1'b0;
    u_host.lvl = ~u_host.lvl; cyc(3);
    u_host.lvl = ~u_host.lvl;
    repeat (8) begin @(negedge clk); v = v | viol; end
    chk(v, 1'b1);
    cyc(12);
  end endtask
  // Single, multi-port and disabled-port receptions
  task t_rx; begin
    dir = 1'b1; en = 8'h0F; e = 8'h00; cyc(4);
    for (i = 0; i < 3; i = i + 1) begin
      rx = 8'(24'hF00F01 >> (8 * i));
      e = e ^ {7'h00, |(rx & en)};
      cyc(1); rx = 8'h00; cyc(1);
      chk(mc_line, e);
    end
  end endtask
  task t_hard; begin
    req = 8'h80; cyc(1); req = 8'h00;
    chk(sr_line, 1'b0);
    rst_n = 1'b0; #1;
    chk(sr_line, 1'b1);
    cyc(2); rst_n = 1'b1; cyc(3);
    chk(sr_line, 1'b1);
  end endtask
  initial begin cyc(10); rst_n = 1'b1; cyc(1); t_soft(1'b0); t_soft(1'b1); t_evt; t_rx; t_hard; give_verdict; end
  initial begin #20000; n_mismatch = n_mismatch + 1; give_verdict; end
endmodule // sideband_pins_tb
